// ---- rtl/disk_task_file_registers.sv ----
// Task file register bank of the drive's host interface
// Behaviour
// - Written count zero means 256 sectors.
// - Count decrements once per sector moved.
// - Successful transfer leaves count at zero.
// - Failed command leaves remaining count.
// - Init and format use count as sectors/track.
// - Sector number increments per sector moved.
// - LBA mode: sector number holds bits 0-7.
// - Cylinder registers track current cylinder.
// - LBA mode: cylinder low holds bits 8-15.
// - LBA mode: cylinder high holds bits 16-23.
// - Drive/head shows current head or LBA 24-27.
// - Drive/head bits 7 and 5 forced to one on each write; reset value 00.
// - Bit 6 selects CHS or LBA.
// - Bit 4 selects master or slave.
// - Bits 3-0 carry head or LBA top.
// - Status refreshed at command end; busy invalidates.
// - Status read clears pending interrupt.
// - Busy set while controller owns registers.
// - Busy within 400 ns of reset; max 30 s.
// - Busy within 400 ns of listed commands.
// - Busy within 5 us per written sector.
// - While busy, command block writes ignored, reads give status.
// - Reset values 01,01,01,00,00,00.
`timescale 1ns/100ps
`default_nettype none
`include "task_file_consts.svh"
module disk_task_file_registers #(
  parameter int RESET_BUSY_MAX = int'(`RESET_BUSY_CYC),
  parameter int ECC_BYTES = 4
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // Host bus
  input wire logic host_cs_cmd_n_in,
  input wire logic host_cs_ctl_n_in,
  input wire logic [2:0] host_da_in,
  input wire logic host_rd_n_in,
  input wire logic host_wr_n_in,
  input wire task_file_pkg::byte_t host_data_in,
  output logic [7:0] host_data_out,
  output logic host_data_oe_out,
  output logic host_intrq_out,
  output logic host_intrq_oe_out,
  // Strap: 0 master, 1 slave
  input wire logic unit_strap_in,
  // Drive controller
  input wire logic ctrl_ready_in,
  input wire logic ctrl_drq_in,
  input wire logic ctrl_sector_done_in,
  input wire logic ctrl_cmd_done_in,
  input wire logic ctrl_cmd_error_in,
  input wire task_file_pkg::byte_t ctrl_error_code_in,
  input wire logic ctrl_release_in,
  // Task file towards the controller
  output logic cmd_strobe_out,
  output logic [7:0] cmd_code_out,
  output logic [7:0] sector_count_out,
  output logic [7:0] sector_number_out,
  output logic [15:0] cylinder_out,
  output logic [7:0] drive_head_out,
  output logic [7:0] sectors_per_track_out,
  output logic [3:0] head_max_out,
  output logic soft_reset_out,
  output logic busy_out,
  output logic block_ready_out
);
  import task_file_pkg::*;
  localparam int SET_MAX = `BUSY_SET_CYC;
  localparam int WR_MAX = `WR_BUSY_CYC;
  localparam logic [9:0] BLOCK_WORDS = 10'(`SECTOR_BYTES / 2);
  localparam logic [9:0] LONG_WORDS = 10'(`SECTOR_BYTES / 2 + ECC_BYTES);
  localparam logic [29:0] RESET_LAST = 30'(RESET_BUSY_MAX - 1);
  byte_t cnt_q, snum_q, cyl_low_q, cyl_high_q, dh_q, err_q, cmd_q, spt_q, data_q;
  logic [3:0] head_max_q;
  logic busy_q, srst_q, nien_q, int_pend_q, st_err_q, drdy_q, drq_q;
  logic wr_prev_n_q, rd_prev_n_q, unit_q, strap_done_q, cmd_strobe_q, block_ready_q;
  logic data_oe_q, intrq_q, intrq_oe_q, long_q;
  logic [9:0] words_q;
  logic [29:0] reset_cnt_q;
  phase_e phase_q;
  // Status byte; bits 5 and 4 are command dependent and read zero here
  function automatic byte_t status_byte(input logic bsy, input logic rdy, input logic drq, input logic err);
    return ({7'h00, bsy} << `ST_BUSY) | ({7'h00, rdy} << `ST_READY) | ({7'h00, drq} << `ST_DRQ)
      | ({7'h00, err} << `ST_ERR);
  endfunction
  function automatic logic busy_cmd(input byte_t c);
    return c[7:4] == `CMD_RECAL_HI || c[7:4] == `CMD_SEEK_HI || c[7:2] == `CMD_READ_HI
      || c[7:1] == `CMD_VERIFY_HI || c == `CMD_DIAG || c == `CMD_INIT_PARAMS
      || c == `CMD_READ_BUF || c == `CMD_IDENTIFY;
  endfunction
  function automatic logic write_cmd(input byte_t c);
    return c[7:2] == `CMD_WRITE_HI || c == `CMD_FORMAT || c == `CMD_WRITE_BUF || c == `CMD_WRITE_MULT;
  endfunction
  function automatic logic geometry_cmd(input byte_t c);
    return c == `CMD_INIT_PARAMS || c == `CMD_FORMAT;
  endfunction
  logic cmd_sel, ctl_sel, wr_edge, rd_edge, selected, reg_wr, cmd_wr, stat_rd, data_wr;
  byte_t status_now;
  assign cmd_sel = !host_cs_cmd_n_in && host_cs_ctl_n_in;
  assign ctl_sel = !host_cs_ctl_n_in && host_cs_cmd_n_in;
  assign wr_edge = wr_prev_n_q && !host_wr_n_in;
  assign rd_edge = rd_prev_n_q && !host_rd_n_in;
  assign selected = dh_q[`DH_UNIT_BIT] == unit_q;
  assign reg_wr = wr_edge && cmd_sel && !busy_q && !srst_q;
  assign cmd_wr = reg_wr && host_da_in == `DA_STATUS && selected;
  assign data_wr = reg_wr && host_da_in == `DA_DATA && selected && phase_q == PH_WDATA;
  assign stat_rd = rd_edge && cmd_sel && host_da_in == `DA_STATUS && selected;
  assign status_now = status_byte(busy_q, drdy_q, drq_q, st_err_q);
  // Strobe edges and strap capture after reset release
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      wr_prev_n_q <= 1'b1;
      rd_prev_n_q <= 1'b1;
      unit_q <= 1'b0;
      strap_done_q <= 1'b0;
    end else begin
      wr_prev_n_q <= host_wr_n_in;
      rd_prev_n_q <= host_rd_n_in;
      if (!strap_done_q) begin
        unit_q <= unit_strap_in;
        strap_done_q <= 1'b1;
      end
    end
  end

  // Device control register
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      srst_q <= 1'b0;
      nien_q <= 1'b0;
    end else if (wr_edge && ctl_sel && host_da_in == `DA_DEV_CTL) begin
      srst_q <= host_data_in[`DC_SRST];
      nien_q <= host_data_in[`DC_NIEN];
    end
  end
  // Sector count
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      cnt_q <= `RST_COUNT;
    end else if (srst_q) begin
      cnt_q <= `RST_COUNT;
    end else if (ctrl_cmd_done_in && !ctrl_cmd_error_in && !geometry_cmd(cmd_q)) begin
      cnt_q <= 8'h00;
    end else if (ctrl_sector_done_in && busy_q) begin
      cnt_q <= cnt_q - 8'h01;
    end else if (reg_wr && host_da_in == `DA_COUNT) begin
      cnt_q <= host_data_in;
    end
  end
  // Address registers: sector, cylinder, drive/head
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      snum_q <= `RST_SNUM;
      cyl_low_q <= `RST_CYL;
      cyl_high_q <= `RST_CYL;
      dh_q <= `RST_DH;
    end else if (srst_q) begin
      snum_q <= `RST_SNUM;
      cyl_low_q <= `RST_CYL;
      cyl_high_q <= `RST_CYL;
      dh_q <= `RST_DH;
    end else if (ctrl_sector_done_in && busy_q) begin
      if (dh_q[`DH_LBA_BIT]) begin
        {dh_q[3:0], cyl_high_q, cyl_low_q, snum_q} <=
          28'({dh_q[3:0], cyl_high_q, cyl_low_q, snum_q} + 28'h0000001);
      end else if (snum_q >= spt_q) begin
        snum_q <= 8'h01;
        if (dh_q[3:0] >= head_max_q) begin
          dh_q[3:0] <= 4'h0;
          {cyl_high_q, cyl_low_q} <= 16'({cyl_high_q, cyl_low_q} + 16'h0001);
        end else begin
          dh_q[3:0] <= dh_q[3:0] + 4'h1;
        end
      end else begin
        snum_q <= snum_q + 8'h01;
      end
    end else if (reg_wr) begin
      unique case (host_da_in)
        `DA_SNUM: snum_q <= host_data_in;
        `DA_CYL_LOW: cyl_low_q <= host_data_in;
        `DA_CYL_HIGH: cyl_high_q <= host_data_in;
        `DA_DRIVE_HEAD: dh_q <= host_data_in | `DH_FIXED;
        default: ;
      endcase
    end
  end
  // Geometry latched by init; format latches only sectors per track
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      spt_q <= `DEF_SPT;
      head_max_q <= `DEF_HEAD_MAX;
    end else if (cmd_wr && geometry_cmd(host_data_in)) begin
      spt_q <= cnt_q;
      if (host_data_in == `CMD_INIT_PARAMS) begin
        head_max_q <= dh_q[3:0];
      end
    end
  end

  // Busy and command phase
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      busy_q <= 1'b1;
      phase_q <= PH_RESET;
      reset_cnt_q <= 30'h00000000;
      words_q <= 10'h000;
      long_q <= 1'b0;
      block_ready_q <= 1'b0;
    end else begin
      block_ready_q <= 1'b0;
      if (srst_q) begin
        busy_q <= 1'b1;
        phase_q <= PH_RESET;
        reset_cnt_q <= 30'h00000000;
      end else begin
        unique case (phase_q)
          PH_RESET: begin
            reset_cnt_q <= reset_cnt_q + 30'h00000001;
            if (ctrl_ready_in || reset_cnt_q >= RESET_LAST) begin
              busy_q <= 1'b0;
              phase_q <= PH_IDLE;
            end
          end
          PH_IDLE: begin
            if (cmd_wr) begin
              busy_q <= busy_cmd(host_data_in) || !write_cmd(host_data_in);
              phase_q <= write_cmd(host_data_in) ? PH_WDATA : PH_EXEC;
              long_q <= host_data_in[7:2] == `CMD_WRITE_HI && host_data_in[`CMD_LONG_BIT];
              words_q <= 10'h000;
            end
          end
          PH_EXEC, PH_WDATA: begin
            if (ctrl_cmd_done_in) begin
              busy_q <= 1'b0;
              phase_q <= PH_IDLE;
            end else if (ctrl_release_in) begin
              busy_q <= 1'b0;
            end else if (data_wr) begin
              if (words_q == (long_q ? LONG_WORDS : BLOCK_WORDS) - 10'h001) begin
                busy_q <= 1'b1;
                block_ready_q <= 1'b1;
                words_q <= 10'h000;
              end else begin
                words_q <= words_q + 10'h001;
              end
            end
          end
        endcase
      end
    end
  end

  // Status, error register and pending interrupt
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      err_q <= `RST_ERROR;
      st_err_q <= 1'b0;
      drdy_q <= 1'b0;
      drq_q <= 1'b0;
      int_pend_q <= 1'b0;
    end else begin
      drdy_q <= ctrl_ready_in;
      drq_q <= ctrl_drq_in;
      if (srst_q) begin
        err_q <= `RST_ERROR;
        st_err_q <= 1'b0;
      end else if (ctrl_cmd_done_in) begin
        err_q <= ctrl_error_code_in;
        st_err_q <= ctrl_cmd_error_in;
      end else if (cmd_wr) begin
        st_err_q <= 1'b0;
      end
      // A new event wins over the acknowledging read
      if (srst_q) begin
        int_pend_q <= 1'b0;
      end else if (ctrl_cmd_done_in || ctrl_release_in) begin
        int_pend_q <= 1'b1;
      end else if (stat_rd) begin
        int_pend_q <= 1'b0;
      end
    end
  end
  // Host read data and pin enables
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      data_q <= 8'h00;
      data_oe_q <= 1'b0;
      intrq_q <= 1'b0;
      intrq_oe_q <= 1'b0;
    end else begin
      data_oe_q <= !host_rd_n_in && selected && ((cmd_sel && host_da_in != `DA_DATA)
        || (ctl_sel && host_da_in == `DA_DEV_CTL));
      intrq_q <= int_pend_q;
      intrq_oe_q <= selected && !nien_q;
      if (rd_edge && (ctl_sel || busy_q)) begin
        data_q <= status_now;
      end else if (rd_edge && cmd_sel) begin
        unique case (host_da_in)
          `DA_ERROR: data_q <= err_q;
          `DA_COUNT: data_q <= cnt_q;
          `DA_SNUM: data_q <= snum_q;
          `DA_CYL_LOW: data_q <= cyl_low_q;
          `DA_CYL_HIGH: data_q <= cyl_high_q;
          `DA_DRIVE_HEAD: data_q <= dh_q;
          `DA_STATUS: data_q <= status_now;
          default: data_q <= 8'h00;
        endcase
      end
    end
  end
  // Command handed to the controller
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      cmd_q <= 8'h00;
      cmd_strobe_q <= 1'b0;
    end else begin
      cmd_strobe_q <= cmd_wr;
      if (cmd_wr) begin
        cmd_q <= host_data_in;
      end
    end
  end

  assign host_data_out = data_q;
  assign host_data_oe_out = data_oe_q;
  assign host_intrq_out = intrq_q;
  assign host_intrq_oe_out = intrq_oe_q;
  assign cmd_strobe_out = cmd_strobe_q;
  assign cmd_code_out = cmd_q;
  assign sector_count_out = cnt_q;
  assign sector_number_out = snum_q;
  assign cylinder_out = {cyl_high_q, cyl_low_q};
  assign drive_head_out = dh_q;
  assign sectors_per_track_out = spt_q;
  assign head_max_out = head_max_q;
  assign soft_reset_out = srst_q;
  assign busy_out = busy_q;
  assign block_ready_out = block_ready_q;

  // Checks
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  sequence s_busy_cmd_taken;
    cmd_wr && busy_cmd(host_data_in);
  endsequence
  sequence s_block_end;
    data_wr && !ctrl_cmd_done_in && !ctrl_release_in
      && words_q == (long_q ? LONG_WORDS : BLOCK_WORDS) - 10'h001;
  endsequence
  logic [29:0] busy_run_q;
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      busy_run_q <= 30'h00000000;
    end else begin
      busy_run_q <= (phase_q == PH_RESET && busy_q && !srst_q) ? busy_run_q + 30'h00000001 : 30'h00000000;
    end
  end

  a_srst_sets_busy: assert property ($rose(srst_q) |-> ##[0:SET_MAX] busy_q)
    else $error("busy late after soft reset");
  a_reset_busy_bound: assert property (busy_run_q <= 30'(RESET_BUSY_MAX))
    else $error("busy held past reset limit");
  a_cmd_sets_busy: assert property (s_busy_cmd_taken |-> ##[1:SET_MAX] busy_q)
    else $error("busy late after command");
  a_block_sets_busy: assert property (s_block_end ##1 !srst_q |-> ##[0:WR_MAX] busy_q)
    else $error("busy late after written block");
  a_count_step: assert property (ctrl_sector_done_in && busy_q && !ctrl_cmd_done_in && !srst_q
    |=> cnt_q == 8'($past(cnt_q) - 8'h01))
    else $error("sector count did not step down");
  a_count_success: assert property (ctrl_cmd_done_in && !ctrl_cmd_error_in && !srst_q
    && !geometry_cmd(cmd_q) |=> cnt_q == 8'h00)
    else $error("count not zero after success");
  a_lba_step: assert property (ctrl_sector_done_in && busy_q && !srst_q && dh_q[`DH_LBA_BIT]
    |=> {dh_q[3:0], cyl_high_q, cyl_low_q, snum_q}
      == 28'($past({dh_q[3:0], cyl_high_q, cyl_low_q, snum_q}) + 28'h0000001))
    else $error("LBA address did not advance");
  a_chs_wrap: assert property (ctrl_sector_done_in && busy_q && !srst_q && !dh_q[`DH_LBA_BIT]
    && snum_q >= spt_q |=> snum_q == 8'h01)
    else $error("sector number did not wrap");
  a_dh_fixed: assert property (reg_wr && host_da_in == `DA_DRIVE_HEAD && !ctrl_sector_done_in
    |=> dh_q[7] && dh_q[5])
    else $error("drive/head fixed bits lost");
  a_int_ack: assert property (stat_rd && !srst_q && !ctrl_cmd_done_in && !ctrl_release_in
    |=> !int_pend_q ##1 !intrq_q)
    else $error("interrupt not cleared by status read");
  a_busy_reads_status: assert property (rd_edge && cmd_sel && busy_q |=> data_q == $past(status_now))
    else $error("read while busy did not give status");
  a_busy_blocks_write: assert property (wr_edge && cmd_sel && busy_q && host_da_in == `DA_COUNT
    && !ctrl_sector_done_in && !ctrl_cmd_done_in && !srst_q |=> $stable(cnt_q))
    else $error("write accepted while busy");
endmodule
`default_nettype wire

// ---- rtl/task_file_consts.svh ----
// Offsets, field positions, reset values, command codes and timing for the task file
`ifndef TASK_FILE_CONSTS_SVH
`define TASK_FILE_CONSTS_SVH
`define DA_DATA 3'h0
`define DA_ERROR 3'h1
`define DA_COUNT 3'h2
`define DA_SNUM 3'h3
`define DA_CYL_LOW 3'h4
`define DA_CYL_HIGH 3'h5
`define DA_DRIVE_HEAD 3'h6
`define DA_STATUS 3'h7
`define DA_DEV_CTL 3'h6
`define DH_LBA_BIT 6
`define DH_UNIT_BIT 4
`define DH_FIXED 8'hA0
`define ST_BUSY 7
`define ST_READY 6
`define ST_DRQ 3
`define ST_ERR 0
`define DC_SRST 2
`define DC_NIEN 1
`define RST_ERROR 8'h01
`define RST_COUNT 8'h01
`define RST_SNUM 8'h01
`define RST_CYL 8'h00
`define RST_DH 8'h00
`define DEF_SPT 8'h3F
`define DEF_HEAD_MAX 4'hF
`define SECTOR_BYTES 512
`define CLK_NS 50
`define BUSY_SET_NS 400
`define BUSY_SET_CYC ((`BUSY_SET_NS) / (`CLK_NS))
`define WR_BUSY_NS 5000
`define WR_BUSY_CYC ((`WR_BUSY_NS) / (`CLK_NS))
`define RESET_BUSY_S 30
`define RESET_BUSY_CYC (64'd1000000000 * (`RESET_BUSY_S) / (`CLK_NS))
`define CMD_RECAL_HI 4'h1
`define CMD_SEEK_HI 4'h7
`define CMD_READ_HI 6'h08
`define CMD_WRITE_HI 6'h0C
`define CMD_LONG_BIT 1
`define CMD_VERIFY_HI 7'h20
`define CMD_FORMAT 8'h50
`define CMD_DIAG 8'h90
`define CMD_INIT_PARAMS 8'h91
`define CMD_WRITE_MULT 8'hC5
`define CMD_READ_BUF 8'hE4
`define CMD_WRITE_BUF 8'hE8
`define CMD_IDENTIFY 8'hEC
`endif

// ---- rtl/task_file_pkg.sv ----
// Types shared by the task file register bank
`default_nettype none
package task_file_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_RESET = 2'b01,
    PH_EXEC = 2'b10,
    PH_WDATA = 2'b11
  } phase_e;
endpackage
`default_nettype wire

// ---- test/host_adapter_model.sv ----
// Host adapter model: one task file access per request on the parallel bus
`timescale 1ns/100ps
`default_nettype none
module host_adapter_model (
  // Clock
  input wire logic mclk_in,
  // Request from the bench
  input wire logic go_in,
  input wire logic wr_in,
  input wire logic ctl_in,
  input wire logic [2:0] addr_in,
  input wire logic [7:0] wdata_in,
  output logic done_out,
  output logic [7:0] rdata_out,
  // Bus towards the device
  input wire logic [7:0] dev_data_in,
  input wire logic dev_oe_in,
  output logic cs_cmd_n_out,
  output logic cs_ctl_n_out,
  output logic [2:0] da_out,
  output logic rd_n_out,
  output logic wr_n_out,
  output logic [7:0] bus_out
);
  logic [2:0] st_q;
  logic [7:0] drv_q;
  logic drive_q;
  logic [7:0] last_q;
  // Undriven bus toggles so a stale value never passes for data
  assign bus_out = dev_oe_in ? dev_data_in : (drive_q ? drv_q : ~last_q);
  initial begin
    st_q = 3'h0;
    drive_q = 1'b0;
    drv_q = 8'h00;
    last_q = 8'h00;
    done_out = 1'b0;
    rdata_out = 8'h00;
    cs_cmd_n_out = 1'b1;
    cs_ctl_n_out = 1'b1;
    da_out = 3'h0;
    rd_n_out = 1'b1;
    wr_n_out = 1'b1;
  end
  always @(posedge mclk_in) begin
    last_q <= bus_out;
    done_out <= 1'b0;
    case (st_q)
      3'h0: if (go_in) begin
        cs_cmd_n_out <= ctl_in;
        cs_ctl_n_out <= ~ctl_in;
        da_out <= addr_in;
        drv_q <= wdata_in;
        drive_q <= wr_in;
        st_q <= 3'h1;
      end
      3'h1: begin
        rd_n_out <= wr_in;
        wr_n_out <= ~wr_in;
        st_q <= 3'h2;
      end
      3'h2: st_q <= 3'h3;
      3'h3: begin
        // Read data answers one edge after the strobe is taken
        rdata_out <= bus_out;
        rd_n_out <= 1'b1;
        wr_n_out <= 1'b1;
        st_q <= 3'h4;
      end
      default: begin
        cs_cmd_n_out <= 1'b1;
        cs_ctl_n_out <= 1'b1;
        drive_q <= 1'b0;
        done_out <= 1'b1;
        st_q <= 3'h0;
      end
    endcase
  end
endmodule
`default_nettype wire

// ---- test/test_disk_task_file_registers.sv ----
// Testbench for the task file register bank
`timescale 1ns/100ps
`default_nettype none
module test_disk_task_file_registers;
  import task_file_pkg::*;
  localparam int RB = 50;
  logic mclk_in, reset_in, go, wr, ctl, done, strap, rdy, drq, sdone, cdone, cerr, rel;
  logic [2:0] addr, da;
  logic [7:0] wdata, rdata, dout, bus, ecode, q;
  logic oe, cs_cmd_n, cs_ctl_n, rd_n, wr_n, intrq, intrq_oe, strobe, srst, busy, blk;
  logic [7:0] code, cnt, snum, dh, spt;
  logic [15:0] cyl;
  logic [3:0] hmax;
  int n_mismatch = 0;
  int checked = 0;
  // One-cycle pulses are counted so a test can judge them later
  int n_strobe = 0;
  int n_blk = 0;
  always @(posedge mclk_in) begin
    if (strobe === 1'b1) n_strobe++;
    if (blk === 1'b1) n_blk++;
  end
  always #25 mclk_in = ~mclk_in;
  host_adapter_model i_host (.mclk_in(mclk_in), .go_in(go), .wr_in(wr), .ctl_in(ctl), .addr_in(addr),
    .wdata_in(wdata), .done_out(done), .rdata_out(rdata), .dev_data_in(dout), .dev_oe_in(oe),
    .cs_cmd_n_out(cs_cmd_n), .cs_ctl_n_out(cs_ctl_n), .da_out(da), .rd_n_out(rd_n), .wr_n_out(wr_n),
    .bus_out(bus));
  disk_task_file_registers #(.RESET_BUSY_MAX(RB), .ECC_BYTES(4)) i_dut (.mclk_in(mclk_in),
    .reset_in(reset_in), .host_cs_cmd_n_in(cs_cmd_n), .host_cs_ctl_n_in(cs_ctl_n), .host_da_in(da),
    .host_rd_n_in(rd_n), .host_wr_n_in(wr_n), .host_data_in(bus), .host_data_out(dout),
    .host_data_oe_out(oe), .host_intrq_out(intrq), .host_intrq_oe_out(intrq_oe), .unit_strap_in(strap),
    .ctrl_ready_in(rdy), .ctrl_drq_in(drq), .ctrl_sector_done_in(sdone), .ctrl_cmd_done_in(cdone),
    .ctrl_cmd_error_in(cerr), .ctrl_error_code_in(ecode), .ctrl_release_in(rel),
    .cmd_strobe_out(strobe), .cmd_code_out(code), .sector_count_out(cnt), .sector_number_out(snum),
    .cylinder_out(cyl), .drive_head_out(dh), .sectors_per_track_out(spt), .head_max_out(hmax),
    .soft_reset_out(srst), .busy_out(busy), .block_ready_out(blk));
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic acc(input logic w, input logic c, input logic [2:0] a, input logic [7:0] d);
    int n;
    n = 0;
    go <= 1'b1;
    wr <= w;
    ctl <= c;
    addr <= a;
    wdata <= d;
    @(posedge mclk_in);
    go <= 1'b0;
    do begin
      @(negedge mclk_in);
      n++;
    end while (done !== 1'b1 && n < 20);
    chk("host access done", 1'b1, done);
    q = rdata;
    @(posedge mclk_in);
  endtask
  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    acc(1'b1, 1'b0, a, d);
  endtask
  task automatic rreg(input logic [2:0] a);
    acc(1'b0, 1'b0, a, 8'h00);
  endtask
  // Controller pulses last one cycle; registers settle one edge later
  task automatic ctl_pulse(input logic s, input logic d, input logic r, input logic e, input logic [7:0] ec);
    sdone <= s;
    cdone <= d;
    rel <= r;
    cerr <= e;
    ecode <= ec;
    @(posedge mclk_in);
    sdone <= 1'b0;
    cdone <= 1'b0;
    rel <= 1'b0;
    repeat (2) @(posedge mclk_in);
  endtask
  task automatic test_reset();
    @(negedge mclk_in);
    chk("busy after reset", 1'b1, busy);
    @(posedge mclk_in);
    rdy <= 1'b1;
    repeat (3) @(posedge mclk_in);
    chk("busy after ready", 1'b0, busy);
    rreg(3'h1);
    chk("error reset", 8'h01, q);
    rreg(3'h2);
    chk("count reset", 8'h01, q);
    rreg(3'h3);
    chk("sector reset", 8'h01, q);
    rreg(3'h4);
    chk("cyl low reset", 8'h00, q);
    rreg(3'h5);
    chk("cyl high reset", 8'h00, q);
    chk("drive head reset", 8'h00, dh);
    $display("test reset done");
  endtask
  task automatic test_chs();
    wreg(3'h2, 8'h02);
    wreg(3'h3, 8'h3F);
    wreg(3'h4, 8'hFF);
    wreg(3'h5, 8'h00);
    wreg(3'h6, 8'h0F);
    chk("drive head fixed bits", 8'hAF, dh);
    wreg(3'h7, 8'h20);
    chk("busy on read", 1'b1, busy);
    chk("command code", 8'h20, code);
    chk("command strobe", 16'h0001, n_strobe[15:0]);
    rreg(3'h2);
    chk("busy read gives status", 8'hC0, q);
    wreg(3'h2, 8'h55);
    chk("busy write ignored", 8'h02, cnt);
    ctl_pulse(1'b1, 1'b0, 1'b0, 1'b0, 8'h00);
    chk("count after sector", 8'h01, cnt);
    chk("sector wraps", 8'h01, snum);
    ctl_pulse(1'b1, 1'b0, 1'b0, 1'b0, 8'h00);
    ctl_pulse(1'b0, 1'b1, 1'b0, 1'b0, 8'h00);
    chk("busy at end", 1'b0, busy);
    chk("count at end", 8'h00, cnt);
    chk("sector at end", 8'h02, snum);
    chk("cylinder crossed", 16'h0100, cyl);
    chk("head wrapped", 8'hA0, dh);
    chk("interrupt pending", 1'b1, intrq);
    chk("interrupt driven", 1'b1, intrq_oe);
    acc(1'b0, 1'b1, 3'h6, 8'h00);
    chk("alternate status", 8'h40, q);
    chk("alternate read keeps interrupt", 1'b1, intrq);
    rreg(3'h7);
    chk("status at end", 8'h40, q);
    chk("interrupt cleared", 1'b0, intrq);
    $display("test chs done");
  endtask
  task automatic test_lba_err();
    wreg(3'h2, 8'h00);
    wreg(3'h3, 8'hFF);
    wreg(3'h4, 8'h34);
    wreg(3'h5, 8'h12);
    wreg(3'h6, 8'hE1);
    wreg(3'h7, 8'h20);
    ctl_pulse(1'b1, 1'b0, 1'b0, 1'b0, 8'h00);
    chk("zero count as 256", 8'hFF, cnt);
    ctl_pulse(1'b0, 1'b1, 1'b0, 1'b1, 8'h04);
    chk("count left on error", 8'hFF, cnt);
    chk("lba low", 8'h00, snum);
    chk("lba middle", 16'h1235, cyl);
    chk("lba top", 8'hE1, dh);
    rreg(3'h7);
    chk("status error", 8'h41, q);
    rreg(3'h1);
    chk("error code", 8'h04, q);
    $display("test lba error done");
  endtask
  task automatic test_init();
    wreg(3'h2, 8'h20);
    wreg(3'h6, 8'h07);
    wreg(3'h7, 8'h91);
    chk("busy on init", 1'b1, busy);
    ctl_pulse(1'b0, 1'b1, 1'b0, 1'b0, 8'h00);
    chk("sectors per track", 8'h20, spt);
    chk("head max", 4'h7, hmax);
    chk("count kept", 8'h20, cnt);
    rreg(3'h7);
    $display("test init done");
  endtask
  task automatic test_write();
    drq <= 1'b1;
    wreg(3'h2, 8'h01);
    wreg(3'h6, 8'h00);
    // Plain write of 256 words, then long write with 4 check bytes more
    for (int k = 0; k < 2; k++) begin
      wreg(3'h7, (k == 0) ? 8'h30 : 8'h32);
      chk("write not busy", 1'b0, busy);
      for (int i = 0; i < ((k == 0) ? 255 : 259); i++) begin
        wreg(3'h0, 8'(i));
      end
      chk("busy before block end", 1'b0, busy);
      wreg(3'h0, 8'hFF);
      chk("busy after block", 1'b1, busy);
      ctl_pulse(1'b0, 1'b0, 1'b1, 1'b0, 8'h00);
      chk("busy after release", 1'b0, busy);
      ctl_pulse(1'b0, 1'b1, 1'b0, 1'b0, 8'h00);
    end
    drq <= 1'b0;
    chk("block ready pulses", 16'h0002, n_blk[15:0]);
    rreg(3'h7);
    $display("test write done");
  endtask
  task automatic test_unit_srst();
    int n;
    wreg(3'h6, 8'h10);
    chk("unit select", 8'hB0, dh);
    chk("other unit no interrupt", 1'b0, intrq_oe);
    wreg(3'h7, 8'h20);
    chk("other unit command", 1'b0, busy);
    chk("other unit strobe", 16'h0005, n_strobe[15:0]);
    rdy <= 1'b0;
    acc(1'b1, 1'b1, 3'h6, 8'h0C);
    chk("soft reset", 1'b1, srst);
    chk("busy in soft reset", 1'b1, busy);
    chk("count re-init", 8'h01, cnt);
    chk("sector re-init", 8'h01, snum);
    chk("cylinder re-init", 16'h0000, cyl);
    chk("drive head re-init", 8'h00, dh);
    acc(1'b1, 1'b1, 3'h6, 8'h08);
    n = 0;
    while (busy !== 1'b0 && n < RB + 5) begin
      @(posedge mclk_in);
      n++;
    end
    chk("reset busy bounded", 1'b0, busy);
    rdy <= 1'b1;
    $display("test unit and soft reset done");
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    mclk_in = 1'b0;
    reset_in = 1'b1;
    {go, wr, ctl, strap, rdy, drq, sdone, cdone, cerr, rel} = '0;
    addr = 3'h0;
    wdata = 8'h00;
    ecode = 8'h00;
    repeat (12) @(posedge mclk_in);
    reset_in <= 1'b0;
    test_reset();
    test_chs();
    test_lba_err();
    test_init();
    test_write();
    test_unit_srst();
    summarize();
  end
  // Whole run needs under 5000 cycles
  initial begin
    repeat (20000) @(posedge mclk_in);
    n_mismatch++;
    summarize();
  end
endmodule
`default_nettype wire
